// *** rtl/swire_cfg.svh ***
// timing and framing constants for the single-wire bus master
// assumes a 10 MHz clock; all times are whole microseconds
`ifndef SWIRE_CFG_SVH
`define SWIRE_CFG_SVH

`define CLK_MHZ 10

// bounds on the line
`define RESET_LOW_MIN_US 480
`define RESET_LOW_MAX_US 960
`define RESET_HIGH_MIN_US 480
`define PRES_SAMPLE_MIN_US 60
`define PRES_SAMPLE_MAX_US 75
`define SLOT_MIN_US 61
`define RECOVERY_MIN_US 1
`define W0_LOW_MIN_US 60
`define W0_LOW_MAX_US 120
`define W1_LOW_MIN_US 1
`define W1_LOW_MAX_US 15
`define READ_LOW_MIN_US 1
`define READ_SAMPLE_MAX_US 15

// operating points inside those bounds
`define PRES_SAMPLE_US 67
`define SLOT_US 70
`define RECOVERY_US 5
`define W0_LOW_US 65
`define W1_LOW_US 6
`define READ_LOW_US 2
`define READ_SAMPLE_US 12

`define PRES_SAMPLE_CYC (`PRES_SAMPLE_US * `CLK_MHZ)
`define SLOT_CYC (`SLOT_US * `CLK_MHZ)
`define RECOVERY_CYC (`RECOVERY_US * `CLK_MHZ)
`define W0_LOW_CYC (`W0_LOW_US * `CLK_MHZ)
`define W1_LOW_CYC (`W1_LOW_US * `CLK_MHZ)
`define READ_LOW_CYC (`READ_LOW_US * `CLK_MHZ)
`define READ_SAMPLE_CYC (`READ_SAMPLE_US * `CLK_MHZ)
`define PRES_SAMPLE_MIN_CYC (`PRES_SAMPLE_MIN_US * `CLK_MHZ)
`define PRES_SAMPLE_MAX_CYC (`PRES_SAMPLE_MAX_US * `CLK_MHZ)
`define SLOT_MIN_CYC (`SLOT_MIN_US * `CLK_MHZ)
`define RECOVERY_MIN_CYC (`RECOVERY_MIN_US * `CLK_MHZ)
`define W0_LOW_MIN_CYC (`W0_LOW_MIN_US * `CLK_MHZ)
`define W0_LOW_MAX_CYC (`W0_LOW_MAX_US * `CLK_MHZ)
`define W1_LOW_MIN_CYC (`W1_LOW_MIN_US * `CLK_MHZ)
`define W1_LOW_MAX_CYC (`W1_LOW_MAX_US * `CLK_MHZ)
`define READ_LOW_MIN_CYC (`READ_LOW_MIN_US * `CLK_MHZ)
`define READ_SAMPLE_MAX_CYC (`READ_SAMPLE_MAX_US * `CLK_MHZ)

// synchroniser latency on the sampled line
`define SYNC_LAG 2
`define BYTE_SLOTS 8
`define TRIPLET_SLOTS 3
`define RESULT_DEPTH 32

`endif

// *** rtl/swire_pkg.sv ***
// types shared by the single-wire bus master
// assumes nothing of its surroundings
package swire_pkg;
    typedef enum logic [2:0] {
        st_idle = 3'h0,
        st_rst_low = 3'h1,
        st_rst_high = 3'h2,
        st_slot = 3'h3,
        st_recover = 3'h4,
        st_done = 3'h5
    } state_type;

    typedef enum logic [1:0] {
        op_reset = 2'h0,
        op_write = 2'h1,
        op_read = 2'h2,
        op_triplet = 2'h3
    } op_type;

    typedef enum logic [1:0] {
        kind_w0 = 2'h0,
        kind_w1 = 2'h1,
        kind_read = 2'h2
    } kind_type;
endpackage

// *** rtl/result_fifo.sv ***
// result buffer: flip-flop fifo with valid/ready on both sides
// assumes depth is a power of two and one clock domain
`timescale 1ns/1ns
module result_fifo #(
    parameter int unsigned width = 8,
    parameter int unsigned depth = 32
) (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [width-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [width-1:0] out_data
);
    localparam int unsigned addr_w = $clog2(depth);

    logic [width-1:0] mem_q [depth];
    logic [addr_w-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [addr_w:0] count_q, count_d;
    logic full_q, full_d, empty_q, empty_d;
    logic push, pop;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        push = in_valid && !full_q;
        pop = out_ready && !empty_q;
        wr_d = push ? wr_q + addr_w'(1) : wr_q;
        rd_d = pop ? rd_q + addr_w'(1) : rd_q;
        count_d = count_q;
        if (push && !pop) begin
            count_d = count_q + (addr_w+1)'(1);
        end else if (pop && !push) begin
            count_d = count_q - (addr_w+1)'(1);
        end
        full_d = count_d == (addr_w+1)'(depth);
        empty_d = count_d == '0;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            wr_q <= '0;
            rd_q <= '0;
            count_q <= '0;
            full_q <= 1'b0;
            empty_q <= 1'b1;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            count_q <= count_d;
            full_q <= full_d;
            empty_q <= empty_d;
        end
    end

    // storage needs no reset; empty_q guards every read
    always_ff @(posedge clock) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    assign in_ready = !full_q;
    assign out_valid = !empty_q;
    assign out_data = mem_q[rd_q];
endmodule

// *** rtl/swire_master.sv ***
// single-wire bus master: reset/presence, byte write, byte read, search triplet
// assumes an external pull-up on the line and a slave that keeps its own timing
`timescale 1ns/1ns
`include "swire_cfg.svh"
module swire_master #(
    parameter int unsigned reset_low_cyc = `RESET_LOW_MIN_US * `CLK_MHZ,
    parameter int unsigned reset_high_cyc = `RESET_HIGH_MIN_US * `CLK_MHZ,
    parameter int unsigned reset_low_max_cyc = `RESET_LOW_MAX_US * `CLK_MHZ
) (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // command port
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [1:0] cmd_op,
    input wire logic [7:0] cmd_data,
    // result stream
    output logic res_valid,
    input wire logic res_ready,
    output logic [7:0] res_data,
    // status
    output logic busy,
    output logic presence,
    // open-drain line
    input wire logic line_in,
    output logic line_out,
    output logic line_oe
);
    swire_pkg::state_type state_q, state_d;
    swire_pkg::op_type op_q, op_d;
    swire_pkg::kind_type kind_q, kind_d;
    logic [13:0] cnt_q, cnt_d;
    logic [3:0] slot_q, slot_d;
    logic [7:0] shift_q, shift_d;
    logic dir_q, dir_d;
    logic oe_q, oe_d;
    logic pres_q, pres_d;
    logic ready_q, ready_d;
    logic busy_q, busy_d;
    logic meta_q, sync_q;
    logic fifo_push, fifo_ready;
    logic [13:0] low_run_q, low_run_d, high_run_q, high_run_d, gap_q, gap_d;

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [13:0] low_len(input swire_pkg::kind_type k);
        unique case (k)
            swire_pkg::kind_w0: low_len = 14'(`W0_LOW_CYC);
            swire_pkg::kind_w1: low_len = 14'(`W1_LOW_CYC);
            swire_pkg::kind_read: low_len = 14'(`READ_LOW_CYC);
            default: low_len = 14'(`READ_LOW_CYC);
        endcase
    endfunction

    // branch bit: follow the slaves when the two read bits differ, else the caller's choice
    function automatic logic search_dir(input logic [7:0] s, input logic d);
        search_dir = (s[0] != s[1]) ? s[0] : d;
    endfunction

    function automatic swire_pkg::kind_type kind_for(input swire_pkg::op_type op, input logic [3:0] slot,
                                                      input logic [7:0] s, input logic d);
        if (op == swire_pkg::op_write) begin
            kind_for = s[0] ? swire_pkg::kind_w1 : swire_pkg::kind_w0;
        end else if (op == swire_pkg::op_triplet && slot == 4'h2) begin
            kind_for = search_dir(s, d) ? swire_pkg::kind_w1 : swire_pkg::kind_w0;
        end else begin
            kind_for = swire_pkg::kind_read;
        end
    endfunction

    function automatic logic [13:0] sat_inc(input logic [13:0] x);
        sat_inc = (x == 14'h3fff) ? x : x + 14'h1;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_d = state_q;
        op_d = op_q;
        kind_d = kind_q;
        cnt_d = cnt_q + 14'h1;
        slot_d = slot_q;
        shift_d = shift_q;
        dir_d = dir_q;
        oe_d = oe_q;
        pres_d = pres_q;
        fifo_push = 1'b0;
        unique case (state_q)
            swire_pkg::st_idle: begin
                cnt_d = 14'h0;
                if (cmd_valid && ready_q) begin
                    op_d = swire_pkg::op_type'(cmd_op);
                    slot_d = 4'h0;
                    dir_d = cmd_data[0];
                    oe_d = 1'b1;
                    shift_d = (op_d == swire_pkg::op_triplet) ? 8'h00 : cmd_data;
                    if (op_d == swire_pkg::op_reset) begin
                        state_d = swire_pkg::st_rst_low;
                    end else begin
                        state_d = swire_pkg::st_slot;
                        kind_d = kind_for(op_d, 4'h0, cmd_data, cmd_data[0]);
                    end
                end
            end
            swire_pkg::st_rst_low: begin
                if (cnt_q == 14'(reset_low_cyc - 1)) begin
                    state_d = swire_pkg::st_rst_high;
                    cnt_d = 14'h0;
                    oe_d = 1'b0;
                end
            end
            swire_pkg::st_rst_high: begin
                if (cnt_q == 14'(`PRES_SAMPLE_CYC)) begin
                    pres_d = !sync_q;
                end
                if (cnt_q == 14'(reset_high_cyc - 1)) begin
                    state_d = swire_pkg::st_done;
                    shift_d = {7'h00, pres_q};
                end
            end
            swire_pkg::st_slot: begin
                oe_d = (cnt_q + 14'h1) < low_len(kind_q);
                if (kind_q == swire_pkg::kind_read && cnt_q == 14'(`READ_SAMPLE_CYC)) begin
                    if (op_q == swire_pkg::op_read) begin
                        shift_d = {sync_q, shift_q[7:1]};
                    end else begin
                        shift_d[slot_q[1:0]] = sync_q;
                    end
                end
                if (cnt_q == 14'(`SLOT_CYC - 1)) begin
                    state_d = swire_pkg::st_recover;
                    cnt_d = 14'h0;
                    oe_d = 1'b0;
                    if (op_q == swire_pkg::op_write) begin
                        shift_d = {1'b0, shift_q[7:1]};
                    end
                end
            end
            swire_pkg::st_recover: begin
                if (cnt_q == 14'(`RECOVERY_CYC - 1)) begin
                    cnt_d = 14'h0;
                    if (slot_q + 4'h1 == ((op_q == swire_pkg::op_triplet) ? 4'(`TRIPLET_SLOTS)
                                                                           : 4'(`BYTE_SLOTS))) begin
                        state_d = swire_pkg::st_done;
                    end else begin
                        slot_d = slot_q + 4'h1;
                        state_d = swire_pkg::st_slot;
                        oe_d = 1'b1;
                        kind_d = kind_for(op_q, slot_d, shift_q, dir_q);
                        if (op_q == swire_pkg::op_triplet) begin
                            shift_d[2] = search_dir(shift_q, dir_q);
                        end
                    end
                end
            end
            swire_pkg::st_done: begin
                // a full buffer holds the master here, except after a write, with the line idle high
                if (op_q == swire_pkg::op_write) begin
                    state_d = swire_pkg::st_idle;
                end else begin
                    fifo_push = 1'b1;
                    if (fifo_ready) begin
                        state_d = swire_pkg::st_idle;
                    end
                end
            end
            default: begin
                state_d = swire_pkg::st_idle;
                oe_d = 1'b0;
            end
        endcase
        ready_d = state_d == swire_pkg::st_idle;
        busy_d = state_d != swire_pkg::st_idle;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            state_q <= swire_pkg::st_idle;
            op_q <= swire_pkg::op_reset;
            kind_q <= swire_pkg::kind_read;
            cnt_q <= 14'h0;
            slot_q <= 4'h0;
            shift_q <= 8'h00;
            dir_q <= 1'b0;
            oe_q <= 1'b0;
            pres_q <= 1'b0;
            ready_q <= 1'b0;
            busy_q <= 1'b0;
            meta_q <= 1'b1;
            sync_q <= 1'b1;
        end else begin
            state_q <= state_d;
            op_q <= op_d;
            kind_q <= kind_d;
            cnt_q <= cnt_d;
            slot_q <= slot_d;
            shift_q <= shift_d;
            dir_q <= dir_d;
            oe_q <= oe_d;
            pres_q <= pres_d;
            ready_q <= ready_d;
            busy_q <= busy_d;
            meta_q <= line_in;
            sync_q <= meta_q;
        end
    end

    result_fifo #(
        .width(8),
        .depth(`RESULT_DEPTH)
    ) u_results (
        .clock(clock),
        .srst(srst),
        .in_valid(fifo_push),
        .in_ready(fifo_ready),
        .in_data(shift_q),
        .out_valid(res_valid),
        .out_ready(res_ready),
        .out_data(res_data)
    );

    assign cmd_ready = ready_q;
    assign busy = busy_q;
    assign presence = pres_q;
    assign line_oe = oe_q;
    // open drain: only ever pulls low
    assign line_out = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // run-length watchers for the checks below
    always_comb begin
        low_run_d = oe_q ? sat_inc(low_run_q) : 14'h0;
        high_run_d = oe_q ? 14'h0 : sat_inc(high_run_q);
        gap_d = (oe_q && low_run_q == 14'h0) ? 14'h1 : sat_inc(gap_q);
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            low_run_q <= 14'h0;
            high_run_q <= 14'h3fff;
            gap_q <= 14'h3fff;
        end else begin
            low_run_q <= low_run_d;
            high_run_q <= high_run_d;
            gap_q <= gap_d;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    a_reset_low_min: assert property (
        $fell(oe_q) && state_q == swire_pkg::st_rst_high |-> low_run_q >= 14'(reset_low_cyc))
        else $error("reset low too short");
    a_reset_low_max: assert property (
        $fell(oe_q) && state_q == swire_pkg::st_rst_high |-> low_run_q <= 14'(reset_low_max_cyc))
        else $error("reset low too long");
    a_reset_high_min: assert property (
        (state_q == swire_pkg::st_rst_high) ##1 (state_q != swire_pkg::st_rst_high)
        |-> high_run_q >= 14'(reset_high_cyc) && !oe_q)
        else $error("reset high time cut short");
    a_presence_window: assert property (
        state_q == swire_pkg::st_rst_high && cnt_q == 14'(`PRES_SAMPLE_CYC)
        |-> high_run_q >= 14'(`PRES_SAMPLE_MIN_CYC + `SYNC_LAG) && high_run_q <= 14'(`PRES_SAMPLE_MAX_CYC)
            ##1 pres_q == !$past(sync_q))
        else $error("presence sampled outside window");
    a_slot_recovery: assert property (
        $rose(oe_q) |-> high_run_q >= 14'(`RECOVERY_MIN_CYC))
        else $error("recovery gap too short");
    a_slot_rate: assert property (
        $rose(oe_q) && state_q == swire_pkg::st_slot |-> gap_q >= 14'(`SLOT_MIN_CYC))
        else $error("slots closer than minimum slot time");
    a_write_zero_low: assert property (
        $fell(oe_q) && state_q == swire_pkg::st_slot && kind_q == swire_pkg::kind_w0
        |-> low_run_q >= 14'(`W0_LOW_MIN_CYC) && low_run_q <= 14'(`W0_LOW_MAX_CYC))
        else $error("write zero low out of range");
    a_write_one_low: assert property (
        $fell(oe_q) && state_q == swire_pkg::st_slot && kind_q == swire_pkg::kind_w1
        |-> low_run_q >= 14'(`W1_LOW_MIN_CYC) && low_run_q <= 14'(`W1_LOW_MAX_CYC))
        else $error("write one low out of range");
    a_read_low: assert property (
        $fell(oe_q) && state_q == swire_pkg::st_slot && kind_q == swire_pkg::kind_read
        |-> low_run_q >= 14'(`READ_LOW_MIN_CYC) && low_run_q < 14'(`READ_SAMPLE_MAX_CYC))
        else $error("read low out of range");
    a_read_sample_time: assert property (
        state_q == swire_pkg::st_slot && kind_q == swire_pkg::kind_read && cnt_q == 14'(`READ_SAMPLE_CYC)
        |-> !oe_q && gap_q + 14'(`SYNC_LAG) <= 14'(`READ_SAMPLE_MAX_CYC))
        else $error("read sampled too late");
    a_search_branch: assert property (
        state_q == swire_pkg::st_slot && op_q == swire_pkg::op_triplet && slot_q == 4'h2
        && shift_q[0] != shift_q[1] |-> kind_q == (shift_q[0] ? swire_pkg::kind_w1 : swire_pkg::kind_w0))
        else $error("search did not follow the only present branch");

    c_presence_seen: cover property (state_q == swire_pkg::st_rst_high ##1 state_q == swire_pkg::st_done && pres_q);
    c_read_pushed: cover property (fifo_push && fifo_ready && op_q == swire_pkg::op_read);
    c_triplet_done: cover property (fifo_push && fifo_ready && op_q == swire_pkg::op_triplet);
    c_buffer_stall: cover property (fifo_push && !fifo_ready);
endmodule

// *** verification/swire_slave_model.sv ***
// behavioural serial-id slave on the shared line, run on the bench clock
// assumes the bench resolves the wire from both pull-downs and a pull-up
`timescale 1ns/1ns
module swire_slave_model #(
    parameter logic [63:0] rom = 64'h0,
    parameter int unsigned rst_min_cyc = 800,
    parameter int unsigned wait_cyc = 200,
    parameter int unsigned low_cyc = 700,
    parameter int unsigned sample_cyc = 300
) (
    // clock
    input wire logic clock,
    // contact and line, no supply pin
    input wire logic attached,
    input wire logic line,
    // pull-down, high while driving low
    output logic pull
);
    // 0 silent, 1 wait, 2 presence low, 3 command, 4 send, 5 search
    int mode = 1;
    int timer = 0;
    int low_n = 0;
    int idx = 0;
    int ph = 0;
    logic prev = 1'b1;
    logic in_slot = 1'b0;
    logic [7:0] cmd = 8'h00;
    logic tx;
    logic rx;
    logic [7:0] full;
    initial pull = 1'b0;

    assign tx = (mode == 5 && ph == 1) ? ~rom[idx] : rom[idx];
    assign rx = mode == 3 || (mode == 5 && ph == 2);
    assign full = {line, cmd[6:0]};

    always @(posedge clock) begin
        prev <= line;
        low_n <= line ? 0 : low_n + 1;
        if (!attached) begin
            mode <= 0;
            pull <= 1'b0;
            in_slot <= 1'b0;
        end else if (line && !prev && low_n >= rst_min_cyc) begin
            mode <= 1;
            timer <= 0;
            in_slot <= 1'b0;
        end else if (mode == 1 || mode == 2) begin
            timer <= timer + 1;
            if (timer == (mode == 1 ? wait_cyc : low_cyc)) begin
                pull <= mode == 1;
                mode <= mode + 1;
                timer <= 0;
                idx <= 0;
            end
        end else if (mode >= 3 && !in_slot && prev && !line) begin
            in_slot <= 1'b1;
            timer <= 1;
            pull <= !rx && !tx;
        end else if (in_slot) begin
            timer <= timer + 1;
            if (timer == sample_cyc) begin
                in_slot <= 1'b0;
                pull <= 1'b0;
                if (mode == 3) begin
                    cmd[idx] <= line;
                    idx <= (idx == 7) ? 0 : idx + 1;
                    ph <= 0;
                    if (idx == 7) mode <= (full inside {8'h33, 8'h0f}) ? 4 : (full == 8'hf0) ? 5 : 0;
                end else if (mode == 4) begin
                    idx <= idx + 1;
                    if (idx == 63) mode <= 0;
                end else if (ph < 2) begin
                    ph <= ph + 1;
                end else begin
                    ph <= 0;
                    idx <= idx + 1;
                    if (line !== rom[idx] || idx == 63) mode <= 0;
                end
            end
        end
    end
endmodule

// *** verification/tb_top.sv ***
// self-checking bench: bus master against the behavioural slave
// assumes shortened reset times through the master's parameters
`timescale 1ns/1ns
module tb_top;
    localparam int unsigned rlow = 900;
    localparam int unsigned rhigh = 1000;
    // family byte and serial are arbitrary
    localparam logic [55:0] id_body = 56'h5a3c96e107d219;

    typedef struct {
        logic [1:0] op;
        logic [7:0] data;
        bit has_res;
        logic [7:0] res;
        logic att;
    } row_type;

    function automatic logic [7:0] crc8(input logic [55:0] v);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < 56; i++) c = (c[0] ^ v[i]) ? ((c >> 1) ^ 8'h8c) : (c >> 1);
        return c;
    endfunction

    localparam logic [63:0] rom_value = {crc8(id_body), id_body};

    logic clock = 1'b0;
    logic srst = 1'b1;
    logic cmd_valid = 1'b0;
    logic res_ready = 1'b0;
    logic attached = 1'b1;
    logic [1:0] cmd_op = 2'h0;
    logic [7:0] cmd_data = 8'h00;
    logic cmd_ready, res_valid, busy, presence, line_in, line_out, line_oe, pull;
    logic [7:0] res_data;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;
    int lo_n = 0;
    int hi_n = 0;
    int per_n = 0;
    int mon_e;
    bit was_rst = 1'b1;
    bit seen = 1'b0;
    row_type rows[$];
    logic [7:0] exp_q[$];

    always #50 clock = ~clock;

    // open drain with pull-up
    assign line_in = (line_oe === 1'b1 ? line_out : 1'b1) & ~pull;

    swire_master #(.reset_low_cyc(rlow), .reset_high_cyc(rhigh), .reset_low_max_cyc(1800)) swire_master_inst (
        .clock(clock), .srst(srst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
        .cmd_data(cmd_data), .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data),
        .busy(busy), .presence(presence), .line_in(line_in), .line_out(line_out), .line_oe(line_oe));

    swire_slave_model #(.rom(rom_value)) swire_slave_model_inst (
        .clock(clock), .attached(attached), .line(line_in), .pull(pull));

    ////////////////////////////////////////////////////////////////////////
    task automatic compare8(input string name, input logic [7:0] e, input logic [7:0] s);
        checks_done++;
        if (s !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", name, e, s);
        end
    endtask

    task automatic compare_range(input string name, input int lo, input int hi, input int s);
        checks_done++;
        if (s < lo || s > hi) begin
            failures++;
            $display("unexpected %s expected %0d..%0d seen %0d", name, lo, hi, s);
        end
    endtask

    task close_out();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task add(input logic [1:0] op, input logic [7:0] d, input bit h, input logic [7:0] r, input logic a);
        rows.push_back('{op, d, h, r, a});
    endtask

    task wait_ready();
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 20000) begin
            @(negedge clock);
            n++;
        end
    endtask

    task do_cmd(input logic [1:0] op, input logic [7:0] d);
        wait_ready();
        cmd_op = op;
        cmd_data = d;
        cmd_valid = 1'b1;
        @(negedge clock);
        cmd_valid = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // line monitor: pulse widths, gaps and slot periods of the master
    always @(negedge clock) begin
        per_n++;
        if (srst) begin
            lo_n = 0;
            seen = 1'b0;
        end else if (line_oe === 1'b1) begin
            if (lo_n == 0 && seen) begin
                compare_range("high gap", was_rst ? rhigh : 10, 1 << 30, hi_n);
                if (!was_rst) compare_range("slot period", 610, 1 << 30, per_n);
            end
            if (lo_n == 0) per_n = 0;
            lo_n++;
        end else begin
            if (lo_n > 0) begin
                mon_e = lo_n > 700 ? rlow : lo_n > 100 ? 650 : lo_n > 40 ? 60 : 20;
                compare_range("low time", mon_e, mon_e, lo_n);
                was_rst = lo_n > 700;
                seen = 1'b1;
                hi_n = 0;
            end
            lo_n = 0;
            hi_n++;
        end
    end

    // the whole run needs about 96500 cycles; a hang stops here
    always @(posedge clock) begin
        cycles++;
        if (cycles == 100000) begin
            failures++;
            $display("unexpected timeout after %0d cycles", cycles);
            close_out();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        add(swire_pkg::op_reset, 8'h00, 1, 8'h01, 1);
        add(swire_pkg::op_write, 8'h0f, 0, 8'h00, 1);
        for (int i = 0; i < 8; i++) add(swire_pkg::op_read, 8'h00, 1, rom_value[8*i +: 8], 1);
        add(swire_pkg::op_reset, 8'h00, 1, 8'h01, 1);
        add(swire_pkg::op_write, 8'h33, 0, 8'h00, 1);
        add(swire_pkg::op_read, 8'h00, 1, rom_value[7:0], 1);
        add(swire_pkg::op_reset, 8'h00, 1, 8'h01, 1);
        add(swire_pkg::op_write, 8'hf0, 0, 8'h00, 1);
        add(swire_pkg::op_triplet, 8'h00, 1, {5'h00, rom_value[0], ~rom_value[0], rom_value[0]}, 1);
        add(swire_pkg::op_triplet, 8'h00, 1, {5'h00, rom_value[1], ~rom_value[1], rom_value[1]}, 1);
        add(swire_pkg::op_reset, 8'h00, 1, 8'h01, 1);
        // unsupported command leaves the line silent: both read bits high
        add(swire_pkg::op_write, 8'h55, 0, 8'h00, 1);
        add(swire_pkg::op_triplet, 8'h01, 1, 8'h07, 1);
        add(swire_pkg::op_reset, 8'h00, 1, 8'h00, 0);
        repeat (4) @(posedge clock);
        @(negedge clock);
        compare8("reset outputs", 8'h00, {3'h0, cmd_ready, busy, presence, line_oe, res_valid});
        $display("test reset done");
        srst = 1'b0;
        // results pile up in the buffer while the reader stalls
        foreach (rows[i]) begin
            attached = rows[i].att;
            do_cmd(rows[i].op, rows[i].data);
            if (rows[i].has_res) exp_q.push_back(rows[i].res);
        end
        wait_ready();
        // last reset ran with no slave on the line
        compare8("idle status", 8'h02, {5'h00, busy, cmd_ready, presence});
        $display("test rows done");
        res_ready = 1'b1;
        // head byte is looked at before the edge that pops it
        for (int n = 0; n < 100 && exp_q.size() > 0; n++) begin
            if (res_valid === 1'b1) compare8("result byte", exp_q.pop_front(), res_data);
            @(negedge clock);
        end
        @(negedge clock);
        compare8("drained", 8'h00, {7'h00, res_valid} | 8'(exp_q.size()));
        res_ready = 1'b0;
        $display("test drain done");
        attached = 1'b1;
        do_cmd(swire_pkg::op_reset, 8'h00);
        do_cmd(swire_pkg::op_read, 8'h00);
        compare8("busy status", 8'h05, {5'h00, busy, cmd_ready, presence});
        repeat (100) @(negedge clock);
        srst = 1'b1;
        repeat (2) @(negedge clock);
        compare8("mid reset outputs", 8'h00, {3'h0, cmd_ready, busy, presence, line_oe, res_valid});
        srst = 1'b0;
        @(negedge clock);
        compare8("ready after reset", 8'h01, {7'h00, cmd_ready});
        $display("test mid reset done");
        close_out();
    end
endmodule
